// [hw/cpurs_regset.sv]
`timescale 1ns/1ps
module cpurs_regset
  import cpurs_pkg::*;
#(
  parameter int NUM_BANKS = GPR_BANKS
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt arbitration view
  input wire logic irqReq,
  input wire logic [1:0] irqLevel,
  output logic irqAccept,
  // Register area address of the current access
  output logic [15:0] gprAddr
);
  // The bank index and the address formula cannot serve more than sixteen banks
  if (NUM_BANKS < 1 || NUM_BANKS > GPR_BANKS) begin : g_bad_banks
    $error("NUM_BANKS out of range");
  end

  localparam int GW = NUM_BANKS * GPR_PER_BANK;

  logic [15:0] pc_q, pc_d;
  logic [15:0] acc_q, acc_d;
  logic [15:0] tmp_q, tmp_d;
  logic [15:0] ix_q, ix_d;
  logic [15:0] ep_q, ep_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0] bank_q, bank_d;
  logic [7:0] ccb_q, ccb_d;
  logic [7:0] gpr_q [GW];
  logic [7:0] gprWrData;
  logic [2:0] gprIdx_q, gprIdx_d;
  logic gprWrite;
  logic [31:0] hrdata_q, hrdata_d;
  logic irqAccept_q, irqAccept_d;
  logic [15:0] gprAddr_q, gprAddr_d;
  // Address phase capture
  logic dpWr_q, dpWr_d, dpRd_q, dpRd_d;
  logic [7:0] dpAddr_q, dpAddr_d;
  // ALU wiring
  logic [7:0] aluRes;
  logic fH, fN, fZ, fV, fC;
  logic [6:0] gIndex;

  cpurs_alu8 u_alu (
    .opA(acc_q[7:0]),
    .opB(tmp_q[7:0]),
    .opSel(hwdata[2:0]),
    .result(aluRes),
    .flagH(fH),
    .flagN(fN),
    .flagZ(fZ),
    .flagV(fV),
    .flagC(fC)
  );

  // Bus slave is zero wait; every register answers in the data phase
  always_comb begin
    dpWr_d = 1'b0;
    dpRd_d = 1'b0;
    dpAddr_d = dpAddr_q;
    if (hsel && hready && htrans[1]) begin
      dpWr_d = hwrite;
      dpRd_d = ~hwrite;
      dpAddr_d = haddr[7:0];
    end
  end

  // Bank-relative register address; the storage index wraps the bank pointer into the usable banks, gprAddr does not
  always_comb begin
    gIndex = 7'((32'(bank_q[3:0]) % NUM_BANKS) * GPR_PER_BANK + 32'(gprIdx_q));
    gprAddr_d = GPR_BASE + {5'h00, bank_q[3:0], 3'h0} + {13'h0000, gprIdx_q};
  end

  // Register updates from bus writes
  always_comb begin
    pc_d = pc_q;
    acc_d = acc_q;
    tmp_d = tmp_q;
    ix_d = ix_q;
    ep_d = ep_q;
    sp_d = sp_q;
    bank_d = bank_q;
    ccb_d = ccb_q;
    gprIdx_d = gprIdx_q;
    gprWrite = 1'b0;
    gprWrData = hwdata[7:0];
    if (dpWr_q) begin
      unique case (dpAddr_q)
        OFF_PC: pc_d = hwdata[15:0];
        OFF_ACC: acc_d = hwdata[15:0];
        OFF_TMP: tmp_d = hwdata[15:0];
        OFF_IX: ix_d = hwdata[15:0];
        OFF_EP: ep_d = hwdata[15:0];
        OFF_SP: sp_d = hwdata[15:0];
        OFF_PSW: begin
          bank_d = hwdata[15:8];
          ccb_d = hwdata[7:0];
        end
        OFF_ALU: begin
          // Byte operation keeps the accumulator's high byte untouched
          acc_d = {acc_q[15:8], aluRes};
          ccb_d[CC_N] = fN;
          ccb_d[CC_Z] = fZ;
          ccb_d[CC_C] = fC;
          if (hwdata[2:1] == 2'b00) begin
            ccb_d[CC_H] = fH;
            ccb_d[CC_V] = fV;
          end
        end
        OFF_GPR: gprWrite = 1'b1;
        OFF_GPADDR: gprIdx_d = hwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux, unmapped words read zero
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (dpRd_d) begin
      unique case (haddr[7:0])
        OFF_PC: hrdata_d = {16'h0000, pc_q};
        OFF_ACC: hrdata_d = {16'h0000, acc_q};
        OFF_TMP: hrdata_d = {16'h0000, tmp_q};
        OFF_IX: hrdata_d = {16'h0000, ix_q};
        OFF_EP: hrdata_d = {16'h0000, ep_q};
        OFF_SP: hrdata_d = {16'h0000, sp_q};
        OFF_PSW: hrdata_d = {16'h0000, bank_q, ccb_q};
        OFF_GPR: hrdata_d = {24'h000000, gpr_q[gIndex]};
        OFF_GPADDR: hrdata_d = {16'h0000, gprAddr_q};
        OFF_IRQ: hrdata_d = {31'h00000000, irqAccept_q};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Lower level number is higher priority; field 3 blocks all
  always_comb begin
    irqAccept_d = irqReq && ccb_q[CC_I] && ({ccb_q[CC_IL1], ccb_q[CC_IL0]} != 2'b11) &&
      (irqLevel < {ccb_q[CC_IL1], ccb_q[CC_IL0]});
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= RST_WORD;
      acc_q <= RST_WORD;
      tmp_q <= RST_WORD;
      ix_q <= RST_WORD;
      ep_q <= RST_WORD;
      sp_q <= RST_WORD;
      bank_q <= 8'h00;
      ccb_q <= RST_CCB;
      gprIdx_q <= 3'h0;
      dpWr_q <= 1'b0;
      dpRd_q <= 1'b0;
      dpAddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      irqAccept_q <= 1'b0;
      gprAddr_q <= GPR_BASE;
    end else begin
      pc_q <= pc_d;
      acc_q <= acc_d;
      tmp_q <= tmp_d;
      ix_q <= ix_d;
      ep_q <= ep_d;
      sp_q <= sp_d;
      bank_q <= bank_d;
      ccb_q <= ccb_d;
      gprIdx_q <= gprIdx_d;
      dpWr_q <= dpWr_d;
      dpRd_q <= dpRd_d;
      dpAddr_q <= dpAddr_d;
      hrdata_q <= hrdata_d;
      irqAccept_q <= irqAccept_d;
      gprAddr_q <= gprAddr_d;
    end
  end

  // Register banks: flops, no reset since RAM content is undefined at reset
  always_ff @(posedge clk) begin
    if (gprWrite) begin
      gpr_q[gIndex] <= gprWrData;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irqAccept = irqAccept_q;
  assign gprAddr = gprAddr_q;

  // Bus steps as sequences: accepted address phase, then for the writes the data phase behind it
  sequence s_pc_write;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == OFF_PC ##1 dpWr_q;
  endsequence
  sequence s_psw_read;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFF_PSW;
  endsequence
  sequence s_gpr_write;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == OFF_GPR ##1 dpWr_q;
  endsequence
  // Data phases of an ALU command; each operation has flag rules of its own
  sequence s_alu_any;
    dpWr_q && dpAddr_q == OFF_ALU;
  endsequence
  sequence s_alu_add;
    dpWr_q && dpAddr_q == OFF_ALU && hwdata[2:0] == 3'(CPURS_ADD);
  endsequence
  sequence s_alu_sub;
    dpWr_q && dpAddr_q == OFF_ALU && hwdata[2:0] == 3'(CPURS_SUB);
  endsequence
  sequence s_alu_shl;
    dpWr_q && dpAddr_q == OFF_ALU && hwdata[2:0] == 3'(CPURS_SHL);
  endsequence
  sequence s_alu_shr;
    dpWr_q && dpAddr_q == OFF_ALU && hwdata[2:0] == 3'(CPURS_SHR);
  endsequence

  // Checks; expectations are rebuilt from operands or from the accumulator result, not from the ALU outputs
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irqAccept_q |-> $past(ccb_q[CC_I]) && !($past(ccb_q[CC_IL1]) && $past(ccb_q[CC_IL0])))
    else $error("interrupt accepted while blocked");
  a_irq_enable: assert property (@(posedge clk) disable iff (rst)
    !ccb_q[CC_I] |=> !irqAccept_q)
    else $error("interrupt accepted while disabled");
  a_level_block: assert property (@(posedge clk) disable iff (rst)
    ccb_q[CC_IL1] && ccb_q[CC_IL0] |=> !irqAccept_q)
    else $error("level 3 did not block");
  a_zero_flag: assert property (@(posedge clk) disable iff (rst)
    s_alu_any |=> ccb_q[CC_Z] == (acc_q[7:0] == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (@(posedge clk) disable iff (rst)
    s_alu_any |=> ccb_q[CC_N] == acc_q[7])
    else $error("negative flag wrong");
  a_acc_high: assert property (@(posedge clk) disable iff (rst)
    s_alu_any |=> acc_q[15:8] == $past(acc_q[15:8]))
    else $error("byte op touched high byte");
  a_shift_carry: assert property (@(posedge clk) disable iff (rst)
    s_alu_shl |=> ccb_q[CC_C] == $past(acc_q[7]))
    else $error("shift carry wrong");
  a_shr_carry: assert property (@(posedge clk) disable iff (rst)
    s_alu_shr |=> ccb_q[CC_C] == $past(acc_q[0]))
    else $error("right shift carry wrong");
  a_add_carry: assert property (@(posedge clk) disable iff (rst)
    s_alu_add |=> ccb_q[CC_C] == (({1'b0, $past(acc_q[7:0])} + {1'b0, $past(tmp_q[7:0])}) > 9'h0FF))
    else $error("add carry wrong");
  a_sub_borrow: assert property (@(posedge clk) disable iff (rst)
    s_alu_sub |=> ccb_q[CC_C] == ($past(acc_q[7:0]) < $past(tmp_q[7:0])))
    else $error("subtract borrow wrong");
  a_half_carry: assert property (@(posedge clk) disable iff (rst)
    s_alu_add |=> ccb_q[CC_H] == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(tmp_q[3:0])}) > 5'h0F))
    else $error("half carry wrong");
  a_half_borrow: assert property (@(posedge clk) disable iff (rst)
    s_alu_sub |=> ccb_q[CC_H] == ($past(acc_q[3:0]) < $past(tmp_q[3:0])))
    else $error("half borrow wrong");
  a_add_ovf: assert property (@(posedge clk) disable iff (rst)
    s_alu_add |=> ccb_q[CC_V] == (($past(acc_q[7]) == $past(tmp_q[7])) && (acc_q[7] != $past(acc_q[7]))))
    else $error("add overflow wrong");
  a_gpr_range: assert property (@(posedge clk) disable iff (rst)
    gprAddr_q >= GPR_BASE && gprAddr_q <= GPR_LAST)
    else $error("register address out of area");
  a_gpr_addr: assert property (@(posedge clk) disable iff (rst)
    ##1 gprAddr_q == GPR_BASE + {5'h00, $past(bank_q[3:0]), 3'h0} + {13'h0000, $past(gprIdx_q)})
    else $error("register address formula");
  a_gpr_write: assert property (@(posedge clk) disable iff (rst)
    s_gpr_write |=> gpr_q[$past(gIndex)] == $past(hwdata[7:0]))
    else $error("banked register write lost");
  a_psw_split: assert property (@(posedge clk) disable iff (rst)
    dpWr_q && dpAddr_q == OFF_PSW |=> bank_q == $past(hwdata[15:8]) && ccb_q == $past(hwdata[7:0]))
    else $error("status word split wrong");
  a_psw_read: assert property (@(posedge clk) disable iff (rst)
    s_psw_read |=> hrdata_q == {16'h0000, $past(bank_q), $past(ccb_q)})
    else $error("status word read wrong");
  a_pc_write: assert property (@(posedge clk) disable iff (rst)
    s_pc_write |=> pc_q == $past(hwdata[15:0]))
    else $error("program counter write lost");
endmodule : cpurs_regset

// [inc/cpurs_pkg.sv]
package cpurs_pkg;
  // Register word offsets on the bus
  localparam logic [7:0] OFF_PC = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_TMP = 8'h08;
  localparam logic [7:0] OFF_IX = 8'h0C;
  localparam logic [7:0] OFF_EP = 8'h10;
  localparam logic [7:0] OFF_SP = 8'h14;
  localparam logic [7:0] OFF_PSW = 8'h18;
  localparam logic [7:0] OFF_ALU = 8'h1C;
  localparam logic [7:0] OFF_GPR = 8'h20;
  localparam logic [7:0] OFF_GPADDR = 8'h24;
  localparam logic [7:0] OFF_IRQ = 8'h28;
  // Condition code byte fields
  localparam int CC_H = 7;
  localparam int CC_I = 6;
  localparam int CC_IL1 = 5;
  localparam int CC_IL0 = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_CCB = 8'h30;
  // Register area layout
  localparam logic [15:0] GPR_BASE = 16'h0100;
  localparam logic [15:0] GPR_LAST = 16'h01FF;
  localparam int GPR_PER_BANK = 8;
  localparam int GPR_BANKS = 16;
  // ALU commands
  typedef enum logic [2:0] {
    CPURS_ADD = 3'b000,
    CPURS_SUB = 3'b001,
    CPURS_SHL = 3'b010,
    CPURS_SHR = 3'b011,
    CPURS_PASS = 3'b100
  } cpurs_op_t;
endpackage : cpurs_pkg

// [hw/cpurs_alu8.sv]
`timescale 1ns/1ps
module cpurs_alu8
  import cpurs_pkg::*;
(
  // Operands
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic [2:0] opSel,
  // Result and flags
  output logic [7:0] result,
  output logic flagH,
  output logic flagN,
  output logic flagZ,
  output logic flagV,
  output logic flagC
);
  logic [8:0] wide;
  logic [4:0] nib;
  logic [7:0] negB;

  // Byte arithmetic; only low bytes of the accumulator pair take part
  always_comb begin
    negB = ~opB;
    wide = 9'h000;
    nib = 5'h00;
    flagH = 1'b0;
    flagV = 1'b0;
    flagC = 1'b0;
    unique case (opSel)
      3'(CPURS_ADD): begin
        wide = {1'b0, opA} + {1'b0, opB};
        nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
        flagH = nib[4];
        flagC = wide[8];
        flagV = (opA[7] == opB[7]) && (wide[7] != opA[7]);
      end
      3'(CPURS_SUB): begin
        wide = {1'b0, opA} + {1'b0, negB} + 9'h001;
        nib = {1'b0, opA[3:0]} - {1'b0, opB[3:0]};
        flagH = nib[4];
        flagC = ~wide[8];
        flagV = (opA[7] != opB[7]) && (wide[7] != opA[7]);
      end
      3'(CPURS_SHL): begin
        wide = {opA, 1'b0};
        flagC = opA[7];
      end
      3'(CPURS_SHR): begin
        wide = {2'b00, opA[7:1]};
        flagC = opA[0];
      end
      default: begin
        wide = {1'b0, opA};
      end
    endcase
    result = wide[7:0];
    flagN = wide[7];
    flagZ = (wide[7:0] == 8'h00);
  end
endmodule : cpurs_alu8

// [tb/cpurs_regset_bench.sv]
`timescale 1ns/1ps
module cpurs_regset_bench
  import cpurs_pkg::*;
;
  // Bus, clock and reset stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic irqReq = 1'b0;
  logic [1:0] irqLevel = 2'h0;
  // Observed outputs
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irqAccept;
  logic [15:0] gprAddr;
  int n_mismatch = 0;
  int tests_run = 0;
  // Op, a, b, result, flags; shifts and pass leave H and V alone so they are masked out
  localparam logic [39:0] ALU_T [13] = '{40'h00_08_08_10_80, 40'h00_7F_01_80_8A, 40'h00_FF_01_00_85,
    40'h00_01_02_03_00, 40'h01_10_01_0F_80, 40'h01_00_01_FF_89, 40'h01_80_01_7F_82, 40'h01_05_05_00_04,
    40'h02_81_00_02_01, 40'h02_40_00_80_08, 40'h03_01_00_00_05, 40'h03_80_00_40_00, 40'h04_80_00_80_08};

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #10 clk = ~clk;

  cpurs_regset #(.NUM_BANKS(16)) dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irqReq(irqReq), .irqLevel(irqLevel), .irqAccept(irqAccept), .gprAddr(gprAddr));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask : chk

  // Ready is sampled at the rising edge, before that edge's updates land, as the slave sees it
  task automatic wrdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wrdy

  // Single word transfer; entered and left just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wrdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask : rdc

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0);
    rdc(OFF_PSW, 32'h0000_0030);
    rdc(OFF_IRQ, 32'h0);
    chk({16'h0, gprAddr}, 32'h0000_0100);
    $display("test reset done");
  endtask : t_reset

  // All six words written before any is read, so aliasing shows; upper half must read 0
  task automatic t_words();
    for (int i = 0; i < 6; i++) wr(8'(4 * i), {16'hFFFF, 16'hA5C3 ^ 16'(i * 16'h1111)});
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), {16'h0, 16'hA5C3 ^ 16'(i * 16'h1111)});
    wr(8'h2C, 32'hFFFF_FFFF);
    rdc(8'h2C, 32'h0);
    rdc(OFF_PC, 32'h0000_A5C3);
    $display("test words done");
  endtask : t_words

  // Flags preset to the opposite of the expected value so stuck bits show
  task automatic t_alu();
    logic [39:0] e;
    logic [7:0] m;
    logic [31:0] x;
    for (int i = 0; i < 13; i++) begin
      e = ALU_T[i];
      m = (e[39:32] >= 8'h02) ? 8'h0D : 8'h8F;
      wr(OFF_ACC, {16'h0, 8'hAB, e[31:24]});
      wr(OFF_TMP, {16'h0, 8'hCD, e[23:16]});
      wr(OFF_PSW, {24'h0, ~e[7:0] & m});
      wr(OFF_ALU, {24'h0, e[39:32]});
      rdc(OFF_ACC, {16'h0, 8'hAB, e[15:8]});
      bus(1'b0, OFF_PSW, 32'h0, x);
      chk({24'h0, x[7:0] & m}, {24'h0, e[7:0]});
    end
    $display("test alu done");
  endtask : t_alu

  // Banks 0, 5, 10, 15 with index bank mod 8, reaching the first and last banked register (0x0100 and 0x017F)
  task automatic t_bank();
    for (int b = 0; b < 16; b += 5) begin
      wr(OFF_PSW, {20'h0, 4'(b), 8'h30});
      wr(OFF_GPADDR, 32'(b % 8));
      wr(OFF_GPR, {24'hFFFFFF, 8'(8'h40 + b)});
      rdc(OFF_GPADDR, 32'(16'h0100 + 8 * b + b % 8));
      chk({16'h0, gprAddr}, 32'(16'h0100 + 8 * b + b % 8));
    end
    for (int b = 0; b < 16; b += 5) begin
      wr(OFF_PSW, {20'h0, 4'(b), 8'h30});
      wr(OFF_GPADDR, 32'(b % 8));
      rdc(OFF_GPR, 32'(8'h40 + b));
    end
    $display("test banks done");
  endtask : t_bank

  // Every enable, level field and request level; accept lags the status word
  task automatic t_irq();
    for (int f = 0; f < 8; f++) begin
      for (int l = 0; l < 4; l++) begin
        irqReq <= 1'b1;
        irqLevel <= 2'(l);
        wr(OFF_PSW, {25'h0, f[2], f[1:0], 4'h0});
        repeat (2) @(posedge clk);
        rdc(OFF_IRQ, 32'(f[2] && l < f[1:0] && f[1:0] != 2'b11));
        chk({31'h0, irqAccept}, 32'(f[2] && l < f[1:0] && f[1:0] != 2'b11));
      end
    end
    irqReq <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, irqAccept}, 32'h0);
    $display("test interrupt gating done");
  endtask : t_irq

  // Reset in mid-run must bring back the cleared enable and blocked level
  task automatic t_rereset();
    wr(OFF_PSW, 32'h0000_FFFF);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFF_PSW, 32'h0000_0030);
    rdc(OFF_SP, 32'h0);
    $display("test second reset done");
  endtask : t_rereset

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_words();
    t_alu();
    t_bank();
    t_irq();
    t_rereset();
    give_verdict();
  end
endmodule : cpurs_regset_bench
